// *** shared/sdm_pkg.sv ***
// shared constants and types for the sixteen-channel system dma
package sdm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 16;
  localparam int CHAN_W = 4;
  localparam int DESC_WORDS = 4;
  localparam int DESC_USED = 3;
  localparam int DESC_AREA_WORDS = 128;
  localparam int APB_AW = 12;
  localparam int VIC_FIRST = 8;
  localparam int VIC_NUM = 4;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_DESC_BASE = 12'h008;
  localparam logic [11:0] OFS_SW_REQ = 12'h00c;
  localparam logic [11:0] OFS_REQ_MASK = 12'h010;
  localparam logic [11:0] OFS_PRIO_HIGH = 12'h014;
  localparam logic [11:0] OFS_ALT_SEL = 12'h018;
  localparam logic [11:0] OFS_DONE_ROUTE = 12'h01c;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_DESC_BASE = 32'h0000_0000;
  localparam logic [15:0] RST_REQ_MASK = 16'h0000;
  localparam logic [15:0] RST_PRIO_HIGH = 16'h0000;
  localparam logic [15:0] RST_ALT_SEL = 16'h0000;
  localparam logic [3:0] RST_DONE_ROUTE = 4'hf;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_ACTIVE_LSB = 16;

  // ----------------------------------------------------------------
  // ahb-lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HBURST_SINGLE = 3'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ----------------------------------------------------------------
  // descriptor layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CYC_STOP = 2'h0,
    CYC_BASIC = 2'h1,
    CYC_AUTO = 2'h2,
    CYC_PINGPONG = 2'h3
  } sdm_cycle_type;

  typedef enum logic [1:0] {
    XFER_MEM2MEM = 2'h0,
    XFER_MEM2PER = 2'h1,
    XFER_PER2MEM = 2'h2,
    XFER_RSVD = 2'h3
  } sdm_xfer_type;

  typedef struct packed {
    logic [13:0] rsvd;
    logic [11:0] count;
    logic [1:0] size;
    sdm_xfer_type xfer;
    sdm_cycle_type cycle;
  } sdm_ctrl_type;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    sdm_ctrl_type ctrl;
  } sdm_desc_type;

  // ----------------------------------------------------------------
  // engine states, gray along fetch-src-dst-writeback-finish
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_SRC = 3'h3,
    ST_DST = 3'h2,
    ST_WBACK = 3'h6,
    ST_FINISH = 3'h7
  } sdm_state_type;

endpackage : sdm_pkg

// *** src/sdm_arbiter.sv ***
// two-level fixed-order channel arbiter
`timescale 1ns/10ps
module sdm_arbiter #(
  parameter int N = 16,
  parameter int IW = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [N-1:0] prio_high,
  output logic grant_valid,
  output logic [IW-1:0] grant_idx
);

  // ----------------------------------------------------------------
  // lowest channel number wins inside a level
  // ----------------------------------------------------------------
  function automatic logic [IW-1:0] lowest_set(input logic [N-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IW'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  wire logic [N-1:0] req_high = req & prio_high;
  wire logic any_high = |req_high;

  assign grant_valid = |req;
  assign grant_idx = any_high ? lowest_set(req_high) : lowest_set(req); // [RULE_05]

endmodule : sdm_arbiter

// *** src/sdm_system_dma.sv ***
// sixteen-channel system dma: apb registers, ahb-lite master, channel handshakes
`timescale 1ns/10ps

// Function
// RULE_01: one 32-bit ahb-lite master moves everything
// RULE_02: registers only through the apb slave
// RULE_03: sixteen independent channels numbered from zero
// RULE_04: each channel owns its handshake lines
// RULE_05: priority level, then lowest channel number
// RULE_06: mem-mem, mem-per, per-mem per descriptor
// RULE_07: several element widths and cycle types
// RULE_08: primary and alternate four-word structures
// RULE_09: descriptors read as little-endian words
// RULE_10: every transfer is single, never a burst
// RULE_11: descriptors fetched from 128x32 sram
// RULE_12: master needs no cpu power domain
// RULE_13: start by hardware or software request
// RULE_14: read descriptor first, write back after
// RULE_15: descriptor gives src, dst, count, size, type
// RULE_16: registers hold config, routing, triggers, base
// RULE_17: bridge issues single or burst requests
// RULE_18: channel 0 from audio port, maskable
// RULE_19: channels 8-11 done routed to vic
// RULE_20: peripherals configured to raise requests
// RULE_21: active while serviced, done pulse at end
// RULE_22: stall input holds off channel transfers
module sdm_system_dma #(
  parameter int NCH = sdm_pkg::NUM_CHAN
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [2:0] HBURST,
  output logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADY,
  input wire logic HRESP,
  input wire logic [NCH-1:0] DMA_REQ,
  input wire logic [NCH-1:0] SINGLE_REQ,
  input wire logic [NCH-1:0] STALL,
  output logic [NCH-1:0] ACTIVE,
  output logic [NCH-1:0] DONE,
  output logic [3:0] VIC_DONE
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] elem_step(input logic [1:0] size);
    return 32'h1 << size;
  endfunction : elem_step
  function automatic logic [31:0] lane_extract(input logic [31:0] d, input logic [1:0] a);
    return d >> {a, 3'h0};
  endfunction : lane_extract
  function automatic logic [31:0] lane_replicate(input logic [31:0] d, input logic [1:0] size);
    return (size == 2'h0) ? {4{d[7:0]}} : (size == 2'h1) ? {2{d[15:0]}} : d;
  endfunction : lane_replicate
  function automatic logic [31:0] desc_word(input sdm_pkg::sdm_desc_type d, input logic [1:0] i);
    return (i == 2'h0) ? d.src : (i == 2'h1) ? d.dst : 32'(d.ctrl);
  endfunction : desc_word

  // ----------------------------------------------------------------
  // register and engine state
  // ----------------------------------------------------------------
  logic enable;
  logic [31:0] desc_base;
  logic [NCH-1:0] sw_pend;
  logic [NCH-1:0] req_mask;
  logic [NCH-1:0] prio_high;
  logic [NCH-1:0] alt_sel;
  logic [3:0] done_route;
  logic bus_err;
  sdm_pkg::sdm_state_type state;
  sdm_pkg::sdm_desc_type desc;
  logic [1:0] phase;
  logic [1:0] widx;
  logic [3:0] chan;
  logic use_alt;
  logic single_mode;
  logic done_flag;
  logic [31:0] data_buf;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic apb_setup = PSEL & ~PENABLE;
  wire logic apb_wr = PSEL & PENABLE & PWRITE; // [RULE_02]
  wire logic [11:0] a = PADDR;
  wire logic hit_ctrl = (a == sdm_pkg::OFS_CTRL);
  wire logic hit_status = (a == sdm_pkg::OFS_STATUS);
  wire logic hit_base = (a == sdm_pkg::OFS_DESC_BASE);
  wire logic hit_swreq = (a == sdm_pkg::OFS_SW_REQ);
  wire logic hit_mask = (a == sdm_pkg::OFS_REQ_MASK);
  wire logic hit_prio = (a == sdm_pkg::OFS_PRIO_HIGH);
  wire logic hit_alt = (a == sdm_pkg::OFS_ALT_SEL);
  wire logic hit_route = (a == sdm_pkg::OFS_DONE_ROUTE);
  wire logic hit_any = hit_ctrl | hit_status | hit_base | hit_swreq | hit_mask | hit_prio
                       | hit_alt | hit_route;
  wire logic busy = (state != sdm_pkg::ST_IDLE);
  wire logic [31:0] status_word = {ACTIVE, 8'h0, chan, 2'h0, bus_err, busy};
  wire logic [31:0] rd_mux =
      hit_ctrl ? {31'h0, enable} :
      hit_status ? status_word :
      hit_base ? desc_base :
      hit_swreq ? {16'h0, sw_pend} :
      hit_mask ? {16'h0, req_mask} :
      hit_prio ? {16'h0, prio_high} :
      hit_alt ? {16'h0, alt_sel} :
      hit_route ? {28'h0, done_route} : 32'h0;

  // ----------------------------------------------------------------
  // request gathering and arbitration
  // ----------------------------------------------------------------
  wire logic [NCH-1:0] hw_req = (DMA_REQ | SINGLE_REQ) & ~req_mask; // [RULE_13] [RULE_18]
  wire logic [NCH-1:0] all_req = hw_req | sw_pend; // [RULE_04]
  logic grant_valid;
  logic [3:0] grant_idx;

  sdm_arbiter #(.N(NCH), .IW(4)) u_arbiter (
    .req(all_req),
    .prio_high(prio_high),
    .grant_valid(grant_valid),
    .grant_idx(grant_idx)
  );

  wire logic start = (state == sdm_pkg::ST_IDLE) & enable & grant_valid;
  // only a bridge single request with nothing stronger moves one element
  wire logic grant_single = SINGLE_REQ[grant_idx] & ~DMA_REQ[grant_idx]
                            & ~sw_pend[grant_idx]; // [RULE_17]

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire logic st_fetch = (state == sdm_pkg::ST_FETCH);
  wire logic st_src = (state == sdm_pkg::ST_SRC);
  wire logic st_dst = (state == sdm_pkg::ST_DST);
  wire logic st_wback = (state == sdm_pkg::ST_WBACK);
  wire logic data_state = st_src | st_dst;
  wire logic bus_state = st_fetch | data_state | st_wback;
  // 128-word area: alternate bit, channel, word index
  wire logic [31:0] desc_addr = desc_base + {23'h0, use_alt, chan, widx, 2'h0}; // [RULE_08] [RULE_11]
  wire logic [31:0] acc_addr = data_state ? (st_src ? desc.src : desc.dst) : desc_addr;
  wire logic [2:0] acc_size = data_state ? {1'b0, desc.ctrl.size} : sdm_pkg::HSIZE_WORD; // [RULE_07]
  wire logic acc_write = st_dst | st_wback;
  wire logic [31:0] acc_wdata = st_wback ? desc_word(desc, widx)
                                         : lane_replicate(data_buf, desc.ctrl.size);
  wire logic issue = bus_state & (phase == 2'h0) & ~(data_state & STALL[chan]); // [RULE_22]
  wire logic acc_done = (phase == 2'h2) & HREADY;

  // ----------------------------------------------------------------
  // descriptor updates
  // ----------------------------------------------------------------
  wire logic src_fixed = (desc.ctrl.xfer == sdm_pkg::XFER_PER2MEM); // [RULE_06]
  wire logic dst_fixed = (desc.ctrl.xfer == sdm_pkg::XFER_MEM2PER);
  wire logic [31:0] step = elem_step(desc.ctrl.size);
  wire logic [31:0] next_src = src_fixed ? desc.src : desc.src + step;
  wire logic [31:0] next_dst = dst_fixed ? desc.dst : desc.dst + step;
  wire logic [11:0] next_count = desc.ctrl.count - 12'h1;
  wire sdm_pkg::sdm_ctrl_type fetched_ctrl = HRDATA; // [RULE_09]
  wire logic finish_done = (state == sdm_pkg::ST_FINISH) & done_flag;
  wire logic pingpong = (desc.ctrl.cycle == sdm_pkg::CYC_PINGPONG);

  // ----------------------------------------------------------------
  // apb slave: answers in the access cycle, data registered in setup
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PRDATA <= (apb_setup & ~PWRITE) ? rd_mux : 32'h0;
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~hit_any;
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      enable <= 1'b0;
      desc_base <= sdm_pkg::RST_DESC_BASE;
      req_mask <= sdm_pkg::RST_REQ_MASK;
      prio_high <= sdm_pkg::RST_PRIO_HIGH;
      done_route <= sdm_pkg::RST_DONE_ROUTE;
    end else if (apb_wr) begin // [RULE_16]
      if (hit_ctrl) enable <= PWDATA[sdm_pkg::CTRL_ENABLE_BIT];
      if (hit_base) desc_base <= {PWDATA[31:2], 2'h0};
      if (hit_mask) req_mask <= PWDATA[NCH-1:0];
      if (hit_prio) prio_high <= PWDATA[NCH-1:0];
      if (hit_route) done_route <= PWDATA[3:0];
    end
  end
  // software trigger: set wins over the grant clear
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      sw_pend <= '0;
    end else begin
      sw_pend <= (sw_pend & ~({NCH{start}} & (NCH'(1) << grant_idx)))
                 | ({NCH{apb_wr & hit_swreq}} & PWDATA[NCH-1:0]); // [RULE_13]
    end
  end
  // alternate select: hardware ping-pong toggle wins over software write
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      alt_sel <= sdm_pkg::RST_ALT_SEL;
    end else if (finish_done & pingpong) begin
      alt_sel[chan] <= ~alt_sel[chan]; // [RULE_08]
    end else if (apb_wr & hit_alt) begin
      alt_sel <= PWDATA[NCH-1:0];
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      bus_err <= 1'b0;
    end else if (acc_done & HRESP) begin
      bus_err <= 1'b1;
    end else if (apb_wr & hit_status & PWDATA[sdm_pkg::STAT_ERR_BIT]) begin
      bus_err <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite master, one non-pipelined single transfer at a time
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase <= 2'h0;
      HADDR <= 32'h0;
      HTRANS <= sdm_pkg::HTRANS_IDLE;
      HWRITE <= 1'b0;
      HSIZE <= sdm_pkg::HSIZE_WORD;
      HBURST <= sdm_pkg::HBURST_SINGLE;
      HWDATA <= 32'h0;
    end else if (issue) begin // [RULE_01] [RULE_12]
      phase <= 2'h1;
      HADDR <= acc_addr;
      HTRANS <= sdm_pkg::HTRANS_NONSEQ;
      HWRITE <= acc_write;
      HSIZE <= acc_size;
      HBURST <= sdm_pkg::HBURST_SINGLE; // [RULE_10]
    end else if ((phase == 2'h1) & HREADY) begin
      phase <= 2'h2;
      HTRANS <= sdm_pkg::HTRANS_IDLE;
      HWDATA <= acc_wdata;
    end else if (acc_done) begin
      phase <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // channel engine
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= sdm_pkg::ST_IDLE;
      chan <= 4'h0;
      use_alt <= 1'b0;
      single_mode <= 1'b0;
      widx <= 2'h0;
      done_flag <= 1'b0;
    end else begin
      unique case (state)
        sdm_pkg::ST_IDLE: begin
          if (start) begin // [RULE_05]
            state <= sdm_pkg::ST_FETCH;
            chan <= grant_idx; // [RULE_03]
            use_alt <= alt_sel[grant_idx];
            single_mode <= grant_single;
            widx <= 2'h0;
            done_flag <= 1'b0;
          end
        end
        sdm_pkg::ST_FETCH: begin // [RULE_14]
          if (acc_done) begin
            widx <= widx + 2'h1;
            if (widx == 2'(sdm_pkg::DESC_USED - 1)) begin
              widx <= 2'h0;
              if (fetched_ctrl.cycle == sdm_pkg::CYC_STOP) begin
                state <= sdm_pkg::ST_FINISH;
              end else if (fetched_ctrl.count == 12'h0) begin
                done_flag <= 1'b1;
                state <= sdm_pkg::ST_WBACK;
              end else begin
                state <= sdm_pkg::ST_SRC;
              end
            end
          end
        end
        sdm_pkg::ST_SRC: begin
          if (acc_done) begin
            state <= sdm_pkg::ST_DST;
          end
        end
        sdm_pkg::ST_DST: begin
          if (acc_done) begin
            if (next_count == 12'h0) begin
              done_flag <= 1'b1;
              state <= sdm_pkg::ST_WBACK;
            end else if (single_mode) begin
              state <= sdm_pkg::ST_WBACK;
            end else begin
              state <= sdm_pkg::ST_SRC;
            end
          end
        end
        sdm_pkg::ST_WBACK: begin // [RULE_14]
          if (acc_done) begin
            widx <= widx + 2'h1;
            if (widx == 2'(sdm_pkg::DESC_USED - 1)) begin
              widx <= 2'h0;
              state <= sdm_pkg::ST_FINISH;
            end
          end
        end
        sdm_pkg::ST_FINISH: begin
          state <= sdm_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // descriptor words and element buffer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      desc <= '0;
      data_buf <= 32'h0;
    end else if (acc_done & st_fetch) begin // [RULE_15]
      if (widx == 2'h0) desc.src <= HRDATA;
      if (widx == 2'h1) desc.dst <= HRDATA;
      if (widx == 2'h2) desc.ctrl <= fetched_ctrl;
    end else if (acc_done & st_src) begin
      data_buf <= lane_extract(HRDATA, desc.src[1:0]);
    end else if (acc_done & st_dst) begin // [RULE_06]
      desc.src <= next_src;
      desc.dst <= next_dst;
      desc.ctrl.count <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // channel handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ACTIVE <= '0;
      DONE <= '0;
      VIC_DONE <= 4'h0;
    end else begin
      ACTIVE <= start ? (NCH'(1) << grant_idx)
              : (state == sdm_pkg::ST_FINISH) ? '0 : ACTIVE; // [RULE_21]
      DONE <= finish_done ? (NCH'(1) << chan) : '0; // [RULE_21]
      VIC_DONE <= (finish_done & (chan[3:2] == 2'h2)) ? ((4'h1 << chan[1:0]) & done_route)
                                                     : 4'h0; // [RULE_19]
    end
  end

endmodule : sdm_system_dma

// *** verif/sdm_ahb_mem.sv ***
// ahb-lite word memory for descriptors and buffers
`timescale 1ns/10ps
module sdm_ahb_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] waits,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hready,
  output logic hresp
);
  // ----------------
  // storage and data phase
  // ----------------
  logic [31:0] mem [0:255];
  logic [31:0] last;
  logic ph, wr;
  logic [7:0] a;
  logic [1:0] w;
  assign hready = !ph || w == 2'h0;
  assign hresp = 1'b0;
  // no stale data outside a read data phase
  assign hrdata = (ph && hready && !wr) ? mem[a] : ~last;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= 1'b0;
      w <= 2'h0;
      last <= 32'h0;
    end else begin
      last <= hrdata;
      if (ph && hready && wr) mem[a] <= hwdata;
      if (htrans == sdm_pkg::HTRANS_NONSEQ && hready) begin
        ph <= 1'b1;
        wr <= hwrite;
        a <= haddr[9:2];
        w <= waits;
      end else if (ph && hready) ph <= 1'b0;
      else if (w != 2'h0) w <= w - 2'h1;
    end
  end
endmodule : sdm_ahb_mem

// *** verif/sdm_system_dma_checker.sv ***
// port assertions for the system dma
`timescale 1ns/10ps
module sdm_system_dma_checker #(
  parameter int NCH = 16
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic [2:0] HSIZE,
  input wire logic [2:0] HBURST,
  input wire logic HREADY,
  input wire logic [NCH-1:0] ACTIVE,
  input wire logic [NCH-1:0] DONE,
  input wire logic [3:0] VIC_DONE
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_single;
    HTRANS == sdm_pkg::HTRANS_NONSEQ |-> HBURST == sdm_pkg::HBURST_SINGLE;
  endproperty
  a_single: assert property (p_single) else $error("burst not single");
  property p_size;
    HTRANS == sdm_pkg::HTRANS_NONSEQ |-> HSIZE <= sdm_pkg::HSIZE_WORD;
  endproperty
  a_size: assert property (p_size) else $error("size beyond bus width");
  property p_pready;
    PSEL && !PENABLE |=> PREADY;
  endproperty
  a_pready: assert property (p_pready) else $error("apb no ready");
  property p_unmapped;
    PSEL && PENABLE && PREADY && PADDR > 12'h01c |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_onehot;
    $onehot0(ACTIVE);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two channels active");
  property p_done;
    |DONE |-> DONE == $past(ACTIVE) && ACTIVE == '0;
  endproperty
  a_done: assert property (p_done) else $error("done without active");
  property p_vic;
    (VIC_DONE & ~DONE[11:8]) == 4'h0;
  endproperty
  a_vic: assert property (p_vic) else $error("stray vic done");
  property p_gap;
    HTRANS == sdm_pkg::HTRANS_NONSEQ && HREADY |=> HTRANS == sdm_pkg::HTRANS_IDLE;
  endproperty
  a_gap: assert property (p_gap) else $error("pipelined transfer");
  property p_hold;
    HTRANS == sdm_pkg::HTRANS_NONSEQ && !HREADY |=> HTRANS == sdm_pkg::HTRANS_NONSEQ
      && $stable(HADDR);
  endproperty
  a_hold: assert property (p_hold) else $error("address not held");
endmodule : sdm_system_dma_checker

bind sdm_system_dma sdm_system_dma_checker #(.NCH(NCH)) i_chk (.CORE_CLK, .RST, .PSEL,
  .PENABLE, .PADDR, .PREADY, .PSLVERR, .HADDR, .HTRANS, .HSIZE, .HBURST, .HREADY, .ACTIVE,
  .DONE, .VIC_DONE);

// *** verif/sdm_system_dma_tb.sv ***
// self-checking bench for the system dma
`timescale 1ns/10ps
module sdm_system_dma_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, hwrite, hready, hresp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, haddr, hwdata, hrdata;
  logic [1:0] htrans, waits;
  logic [15:0] dreq, sreq, stall, active, done;
  logic [3:0] vectored_irq_controller, vacc;
  int q[$];
  int error_cnt, n_tests;
  sdm_system_dma i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(),
    .HBURST(), .HWDATA(hwdata), .HRDATA(hrdata), .HREADY(hready), .HRESP(hresp),
    .DMA_REQ(dreq), .SINGLE_REQ(sreq), .STALL(stall), .ACTIVE(active), .DONE(done),
    .VIC_DONE(vectored_irq_controller));
  sdm_ahb_mem i_mem (.clk, .rst, .waits, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
    .hready, .hresp);
  // ----------------
  // clock, logging, watchdog
  // ----------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 16; i++) if (done[i] === 1'b1) q.push_back(i);
    vacc <= rst ? 4'h0 : vacc | vectored_irq_controller;
  end
  initial begin
    #100000;
    error_cnt++;
    $display("MISMATCH t=%0t watchdog", $time);
    summarize();
  end
  // ----------------
  // tasks
  // ----------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic err);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    chk({30'h0, pready, pslverr}, {30'h0, 1'b1, err});
    if (!w) chk(prdata, d);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic hold(input int ch);
    int t;
    t = 0;
    while (active[ch] !== 1'b1 && t < 500) begin
      @(posedge clk);
      t++;
    end
    chk({31'h0, active[ch]}, 32'h1);
    dreq[ch] <= 1'b0;
    sreq[ch] <= 1'b0;
    while (active[ch] !== 1'b0 && t < 900) begin
      @(posedge clk);
      t++;
    end
    chk({31'h0, active[ch]}, 32'h0);
    @(posedge clk);
  endtask : hold
  task automatic desc(input int ch, input int n);
    sdm_pkg::sdm_ctrl_type c;
    c = '0;
    c.count = 12'(n);
    c.size = 2'h2;
    c.xfer = sdm_pkg::XFER_MEM2MEM;
    c.cycle = sdm_pkg::CYC_BASIC;
    i_mem.mem[ch*4] = 32'(32'h200 + ch*16);
    i_mem.mem[ch*4+1] = 32'(32'h300 + ch*16);
    i_mem.mem[ch*4+2] = c;
    for (int k = 0; k < n; k++) begin
      i_mem.mem[128+ch*4+k] = 32'hc0de_0000 + 32'(ch*16+k);
      i_mem.mem[192+ch*4+k] = 32'h0;
    end
  endtask : desc
  task automatic cmp(input int ch, input int n);
    for (int k = 0; k < n; k++) chk(i_mem.mem[192+ch*4+k], 32'hc0de_0000 + 32'(ch*16+k));
    chk(32'(i_mem.mem[ch*4+2][17:6]), 32'h0);
  endtask : cmp
  // ----------------
  // sequence
  // ----------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {dreq, sreq, stall, waits} = '0;
    error_cnt = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, sdm_pkg::OFS_DESC_BASE, sdm_pkg::RST_DESC_BASE, 0);
    apb(0, sdm_pkg::OFS_REQ_MASK, 32'(sdm_pkg::RST_REQ_MASK), 0);
    apb(0, sdm_pkg::OFS_ALT_SEL, 32'(sdm_pkg::RST_ALT_SEL), 0);
    apb(0, sdm_pkg::OFS_DONE_ROUTE, 32'(sdm_pkg::RST_DONE_ROUTE), 0);
    apb(0, sdm_pkg::OFS_STATUS, 32'h0, 0);
    apb(0, 12'h040, 32'h0, 1);
    apb(1, sdm_pkg::OFS_PRIO_HIGH, 32'h200, 0);
    apb(0, sdm_pkg::OFS_PRIO_HIGH, 32'h200, 0);
    apb(1, sdm_pkg::OFS_CTRL, 32'h1, 0);
    for (int s = 0; s < 2; s++) begin
      waits <= 2'(s * 2);
      desc(3, 4);
      apb(1, sdm_pkg::OFS_SW_REQ, 32'h8, 0);
      hold(3);
      cmp(3, 4);
      chk(32'(q[$]), 32'd3);
    end
    chk(32'(vacc), 32'h0);
    desc(5, 2);
    desc(9, 3);
    dreq <= 16'h0220;
    hold(9);
    hold(5);
    chk(32'(q[q.size()-2]), 32'd9);
    cmp(9, 3);
    cmp(5, 2);
    chk(32'(vacc), 32'h2);
    apb(1, sdm_pkg::OFS_REQ_MASK, 32'h1, 0);
    desc(0, 1);
    dreq[0] <= 1'b1;
    repeat (30) @(posedge clk);
    chk(32'(active), 32'h0);
    apb(1, sdm_pkg::OFS_REQ_MASK, 32'h0, 0);
    hold(0);
    cmp(0, 1);
    desc(3, 2);
    stall[3] <= 1'b1;
    apb(1, sdm_pkg::OFS_SW_REQ, 32'h8, 0);
    repeat (40) @(posedge clk);
    chk(i_mem.mem[204], 32'h0);
    stall[3] <= 1'b0;
    hold(3);
    cmp(3, 2);
    desc(12, 3);
    for (int k = 0; k < 3; k++) begin
      sreq[12] <= 1'b1;
      hold(12);
      chk(32'(i_mem.mem[50][17:6]), 32'(2 - k));
    end
    chk(32'(q[$]), 32'd12);
    cmp(12, 3);
    desc(7, 2);
    i_mem.mem[30][3:2] = sdm_pkg::XFER_PER2MEM;
    apb(1, sdm_pkg::OFS_SW_REQ, 32'h80, 0);
    hold(7);
    for (int k = 0; k < 2; k++) chk(i_mem.mem[220+k], 32'hc0de_0070);
    chk(i_mem.mem[28], 32'h270);
    chk(i_mem.mem[29], 32'h378);
    summarize();
  end
endmodule : sdm_system_dma_tb
